// ---- src/psp_device.sv ----
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Unit end: pin timing, mode changes, responses and settings.
module psp_device
    import psp_pkg::*;
#(
    parameter int unsigned RST_CYC  = RST_HOLD_CYC,
    parameter int unsigned PAIR_CYC = PAIR_HOLD_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    psp_if.device            pins,
    input  wire logic        i_link_up,
    input  wire logic        i_cmd_done,
    input  wire logic        i_cmd_ok,
    input  wire logic        i_set_valid,
    input  wire psp_mode_t   i_set_mode,
    input  wire logic        i_set_auth,
    input  wire logic        i_set_encr,
    input  wire logic        i_set_rsp_en,
    input  wire logic [15:0] i_set_pin,
    output logic             o_defaults,
    output psp_mode_t        o_mode,
    output logic             o_master,
    output logic             o_auth_en,
    output logic             o_encr_en,
    output logic [15:0]      o_pin_code,
    output logic             o_rsp_en,
    output logic             o_pairing
);

    // ========================================================
    // State.
    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  pair_sync;
        logic        pair_prev;
        logic [31:0] rst_cnt;
        logic [31:0] pair_cnt;
        psp_pair_t   pst;
        psp_mode_t   mode;
        logic        master;
        logic        link;
        logic        auth;
        logic        encr;
        logic [15:0] pin;
        logic        rsp_en;
        logic        rsp_valid;
        psp_rsp_t    rsp_kind;
        logic        defaults;
    } psp_dev_t;

    localparam psp_dev_t DEV_RESET = '{
        rst_sync:  2'h3,
        pair_sync: 2'h3,
        pair_prev: 1'b1,
        rst_cnt:   32'h0,
        pair_cnt:  32'h0,
        pst:       P_IDLE,
        mode:      command_wait_mode,
        master:    1'b0,
        link:      1'b0,
        auth:      RST_AUTH,
        encr:      RST_ENCR,
        pin:       RST_PIN,
        rsp_en:    RST_RSP_EN,
        rsp_valid: 1'b0,
        rsp_kind:  RSP_ACK,
        defaults:  1'b0
    };

    psp_dev_t s_q;
    psp_dev_t s_d;

    // Saturating increment so a long hold never wraps and refires.
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h1;
    endfunction

    logic rst_low;
    logic pair_lvl;
    logic pair_held;
    logic link_rise;
    logic link_fall;
    logic rsp_allowed;

    always_comb begin
        s_d = s_q;
        rst_low   = ~s_q.rst_sync[1];
        pair_lvl  = s_q.pair_sync[1];
        link_rise = i_link_up & ~s_q.link;
        link_fall = ~i_link_up & s_q.link;

        // Pins arrive from another chip and pass two flops first.
        s_d.rst_sync  = {s_q.rst_sync[0], pins.rst_n};
        s_d.pair_sync = {s_q.pair_sync[0], pins.pair_n};
        s_d.pair_prev = pair_lvl;
        s_d.defaults  = 1'b0;
        s_d.rsp_valid = 1'b0;

        if (pair_lvl != s_q.pair_prev) begin
            s_d.pair_cnt = 32'h1;
        end else begin
            s_d.pair_cnt = sat_inc(s_q.pair_cnt);
        end
        // The hold fires exactly once, when the level has stood long
        // enough; anything shorter never reaches the compare.
        pair_held = (pair_lvl == s_q.pair_prev)
                  && (s_q.pair_cnt == PAIR_CYC - 1);

        s_d.link = i_link_up;

        if (i_set_valid) begin
            s_d.mode = i_set_mode;
        end
        if (i_set_valid) begin
            s_d.auth = i_set_auth;
            s_d.encr = i_set_encr;
            s_d.pin  = i_set_pin;
        end
        if (i_set_valid) begin
            s_d.rsp_en = i_set_rsp_en;
        end

        case (s_q.pst)
            P_IDLE: begin
                if (pair_held && !pair_lvl && !rst_low) begin
                    s_d.mode   = open_accept_mode;
                    s_d.pst    = P_OPEN;
                    s_d.rsp_en = 1'b0;
                end
            end
            P_OPEN: begin
                if (link_rise) begin
                    s_d.pst = P_IDLE;
                end else if (pair_held && pair_lvl) begin
                    s_d.pst = P_ARMED;
                end
            end
            P_ARMED: begin
                if (link_rise) begin
                    s_d.pst = P_IDLE;
                end else if (pair_held && !pair_lvl) begin
                    s_d.mode = reconnect_initiate_mode;
                    s_d.pst  = P_INIT;
                end
            end
            P_INIT: begin
                if (link_rise) begin
                    s_d.pst = P_IDLE;
                end
            end
            default: begin
                s_d.pst = P_IDLE;
            end
        endcase

        if (link_rise && s_q.pst == P_INIT) begin
            s_d.master = 1'b1;
        end else if (link_rise && s_q.pst != P_IDLE) begin
            // The first unit keeps waiting for this partner from now
            // on, so both ends reconnect after a restart.
            s_d.master = 1'b0;
            s_d.mode   = reconnect_accept_mode;
        end else if (link_rise) begin
            s_d.master = (s_q.mode == reconnect_initiate_mode);
        end

        rsp_allowed = s_q.rsp_en && (s_q.pst == P_IDLE) && !link_rise;
        if (s_q.rsp_en && s_q.pst == P_IDLE) begin
            if (link_rise) begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_kind  = RSP_CONNECT;
            end else if (link_fall) begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_kind  = RSP_DISCONNECT;
            end else if (i_cmd_done) begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_kind  = i_cmd_ok ? RSP_ACK : RSP_ERROR;
            end
        end
        if (!rsp_allowed && !link_rise) begin
            s_d.rsp_valid = s_d.rsp_valid & s_q.rsp_en
                          & (s_q.pst == P_IDLE);
        end

        if (!rst_low) begin
            s_d.rst_cnt = 32'h0;
        end else begin
            s_d.rst_cnt = sat_inc(s_q.rst_cnt);
        end
        if (rst_low && s_q.rst_cnt == RST_CYC - 1) begin
            s_d.mode     = command_wait_mode;
            s_d.pst      = P_IDLE;
            s_d.master   = 1'b0;
            s_d.auth     = RST_AUTH;
            s_d.encr     = RST_ENCR;
            s_d.pin      = RST_PIN;
            s_d.rsp_en   = RST_RSP_EN;
            s_d.defaults = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs.
    // Active low detect
    assign pins.link_detect_out_n = ~s_q.link;
    assign pins.rsp_valid         = s_q.rsp_valid;
    assign pins.rsp_kind          = s_q.rsp_kind;
    assign o_defaults             = s_q.defaults;
    assign o_mode                 = s_q.mode;
    assign o_master               = s_q.master;
    assign o_auth_en              = s_q.auth;
    assign o_encr_en              = s_q.encr;
    assign o_pin_code             = s_q.pin;
    assign o_rsp_en               = s_q.rsp_en;
    assign o_pairing              = (s_q.pst != P_IDLE);

endmodule
`default_nettype wire

// ---- pkg/psp_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants and types for the pairing and status pins.
package psp_pkg;

    // ========================================================
    // Timing.
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned RST_HOLD_MS   = 1000;
    localparam int unsigned PAIR_HOLD_MS  = 2000;
    localparam int unsigned RST_HOLD_CYC  = (CLK_HZ / 1000) * RST_HOLD_MS;
    localparam int unsigned PAIR_HOLD_CYC = (CLK_HZ / 1000) * PAIR_HOLD_MS;

    // ========================================================
    // Device settings after a factory restore.
    localparam logic        RST_RSP_EN = 1'b1;
    localparam logic        RST_AUTH   = 1'b0;
    localparam logic        RST_ENCR   = 1'b0;
    localparam logic [15:0] RST_PIN    = 16'h0000;

    // ========================================================
    // Controller register map (word index) and field positions.
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam int CTRL_RESET   = 0;
    localparam int CTRL_FIRST   = 1;
    localparam int CTRL_SECOND  = 2;
    localparam int ST_BUSY      = 0;
    localparam int ST_LINK      = 1;
    localparam int ST_KIND_LSB  = 2;
    localparam int IRQ_LINK_UP  = 0;
    localparam int IRQ_LINK_DN  = 1;
    localparam int IRQ_RSP      = 2;
    localparam int IRQ_DONE     = 3;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // ========================================================
    // Enumerations.
    typedef enum logic [1:0] {
        command_wait_mode       = 2'h0,
        reconnect_initiate_mode = 2'h1,
        reconnect_accept_mode   = 2'h2,
        open_accept_mode        = 2'h3
    } psp_mode_t;

    typedef enum logic [1:0] {
        RSP_ACK        = 2'h0,
        RSP_ERROR      = 2'h1,
        RSP_CONNECT    = 2'h2,
        RSP_DISCONNECT = 2'h3
    } psp_rsp_t;

    typedef enum logic [1:0] {
        P_IDLE  = 2'h0,
        P_OPEN  = 2'h1,
        P_ARMED = 2'h3,
        P_INIT  = 2'h2
    } psp_pair_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LOW1 = 3'h1,
        H_HIGH = 3'h3,
        H_LOW2 = 3'h2,
        H_RST  = 3'h4
    } psp_seq_t;

endpackage
`default_nettype wire

// ---- pkg/psp_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Pins between the host controller and the serial-cable unit.
interface psp_if;
    import psp_pkg::*;
    logic     rst_n;
    logic     pair_n;
    logic     link_detect_out_n;
    logic     rsp_valid;
    psp_rsp_t rsp_kind;

    modport device (
        input  rst_n,
        input  pair_n,
        output link_detect_out_n,
        output rsp_valid,
        output rsp_kind
    );
    modport host (
        output rst_n,
        output pair_n,
        input  link_detect_out_n,
        input  rsp_valid,
        input  rsp_kind
    );
endinterface
`default_nettype wire

// ---- src/psp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host end: drives the reset and pairing pins with timed holds and
// reports link and response events to software.
module psp_host
    import psp_pkg::*;
#(
    parameter int unsigned RST_CYC  = RST_HOLD_CYC,
    parameter int unsigned PAIR_CYC = PAIR_HOLD_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    psp_if.host              pins,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    output logic             o_irq
);

    typedef struct packed {
        logic [1:0]  link_sync;
        logic        link_prev;
        psp_seq_t    seq;
        logic        second;
        logic [31:0] timer;
        logic        rst_n;
        logic        pair_n;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        psp_rsp_t    last_kind;
        logic [31:0] rdata;
    } psp_host_t;

    localparam psp_host_t HOST_RESET = '{
        link_sync: 2'h0, link_prev: 1'b0, seq: H_IDLE, second: 1'b0,
        timer: 32'h0, rst_n: 1'b1, pair_n: 1'b1, irq_stat: 4'h0,
        irq_mask: RST_IRQ_MASK, last_kind: RSP_ACK, rdata: 32'h0
    };

    psp_host_t h_q;
    psp_host_t h_d;

    logic       link;
    logic       expired;
    logic [3:0] set;
    logic [3:0] clr;

    always_comb begin
        h_d = h_q;
        // Detect pin is active low; stored here active high.
        h_d.link_sync = {h_q.link_sync[0], ~pins.link_detect_out_n};
        link          = h_q.link_sync[1];
        h_d.link_prev = link;
        expired       = (h_q.timer == 32'h0);
        h_d.timer     = expired ? 32'h0 : h_q.timer - 32'h1;
        set = 4'h0;
        clr = 4'h0;
        set[IRQ_LINK_UP] = link & ~h_q.link_prev;
        set[IRQ_LINK_DN] = ~link & h_q.link_prev;
        set[IRQ_RSP]     = pins.rsp_valid;
        if (pins.rsp_valid) begin
            h_d.last_kind = pins.rsp_kind;
        end

        case (h_q.seq)
            H_IDLE: begin
                if (i_wr && i_addr == REG_CTRL) begin
                    if (i_wdata[CTRL_RESET]) begin
                        h_d.seq   = H_RST;
                        h_d.rst_n = 1'b0;
                        h_d.timer = RST_CYC - 1;
                    end else if (i_wdata[CTRL_FIRST]
                                 || i_wdata[CTRL_SECOND]) begin
                        h_d.seq    = H_LOW1;
                        h_d.second = i_wdata[CTRL_SECOND];
                        h_d.pair_n = 1'b0;
                        h_d.timer  = PAIR_CYC - 1;
                    end
                end
            end
            H_RST: begin
                if (expired) begin
                    h_d.seq   = H_IDLE;
                    h_d.rst_n = 1'b1;
                    set[IRQ_DONE] = 1'b1;
                end
            end
            H_LOW1: begin
                if (expired) begin
                    h_d.pair_n = 1'b1;
                    if (h_q.second) begin
                        h_d.seq   = H_HIGH;
                        h_d.timer = PAIR_CYC - 1;
                    end else begin
                        h_d.seq       = H_IDLE;
                        set[IRQ_DONE] = 1'b1;
                    end
                end
            end
            H_HIGH: begin
                if (expired) begin
                    h_d.seq    = H_LOW2;
                    h_d.pair_n = 1'b0;
                    h_d.timer  = PAIR_CYC - 1;
                end
            end
            H_LOW2: begin
                if (expired) begin
                    h_d.seq       = H_IDLE;
                    h_d.pair_n    = 1'b1;
                    set[IRQ_DONE] = 1'b1;
                end
            end
            default: begin
                h_d.seq    = H_IDLE;
                h_d.rst_n  = 1'b1;
                h_d.pair_n = 1'b1;
            end
        endcase

        if (i_wr && i_addr == REG_IRQ_STAT) begin
            clr = i_wdata[3:0];
        end
        if (i_wr && i_addr == REG_IRQ_MASK) begin
            h_d.irq_mask = i_wdata[3:0];
        end
        // A new event in the clearing cycle survives the clear.
        h_d.irq_stat = (h_q.irq_stat & ~clr) | set;

        h_d.rdata = 32'h0;
        if (i_rd) begin
            case (i_addr)
                REG_STATUS: begin
                    h_d.rdata[ST_BUSY] = (h_q.seq != H_IDLE);
                    h_d.rdata[ST_LINK] = link;
                    h_d.rdata[ST_KIND_LSB +: 2] = h_q.last_kind;
                end
                REG_IRQ_STAT: h_d.rdata[3:0] = h_q.irq_stat;
                REG_IRQ_MASK: h_d.rdata[3:0] = h_q.irq_mask;
                default:      h_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            h_q <= HOST_RESET;
        end else begin
            h_q <= h_d;
        end
    end

    assign pins.rst_n  = h_q.rst_n;
    assign pins.pair_n = h_q.pair_n;
    assign o_rdata     = h_q.rdata;
    assign o_irq       = |(h_q.irq_stat & h_q.irq_mask);

endmodule
`default_nettype wire

// ---- verif/psp_checker_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Pin checks on the interface that joins the host and the unit.
module psp_checker
    import psp_pkg::*;
#(
    parameter int unsigned RST_CYC  = 20,
    parameter int unsigned PAIR_CYC = 40
) (
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire logic     rst_n,
    input  wire logic     pair_n,
    input  wire logic     link_detect_out_n,
    input  wire logic     rsp_valid,
    input  wire psp_rsp_t rsp_kind
);
    logic [15:0] rst_lo_q;
    logic [15:0] pair_lo_q;
    logic [15:0] pair_hi_q;
    logic        armed_q;

    // ========================================================
    // Run lengths of the pin levels.
    // The high run starts saturated so that the first fall after
    // reset is never mistaken for a short gap.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_lo_q  <= 16'h0;
            pair_lo_q <= 16'h0;
            pair_hi_q <= 16'hffff;
            armed_q   <= 1'b0;
        end else begin
            rst_lo_q  <= rst_n ? 16'h0 : rst_lo_q + 16'h1;
            pair_lo_q <= pair_n ? 16'h0 : pair_lo_q + 16'h1;
            if (!pair_n) begin
                pair_hi_q <= 16'h0;
            end else if (pair_hi_q != 16'hffff) begin
                pair_hi_q <= pair_hi_q + 16'h1;
            end
            // Armed by a full low step; p_quiet adds synchroniser slack.
            if (!rst_n || !link_detect_out_n) begin
                armed_q <= 1'b0;
            end else if (pair_lo_q == 16'(PAIR_CYC)) begin
                armed_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // ========================================================
    // Properties.
    sequence s_rst_held;
        !rst_n [*8];
    endsequence
    sequence s_pair_held;
        !pair_n [*8];
    endsequence

    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    property p_conn_linked;
        rsp_valid && rsp_kind == RSP_CONNECT |-> !link_detect_out_n;
    endproperty
    property p_disc_unlinked;
        rsp_valid && rsp_kind == RSP_DISCONNECT |-> link_detect_out_n;
    endproperty
    property p_rst_min;
        $fell(rst_n) |-> s_rst_held;
    endproperty
    property p_rst_exact;
        $rose(rst_n) |-> rst_lo_q == 16'(RST_CYC);
    endproperty
    property p_pair_min;
        $fell(pair_n) |-> s_pair_held;
    endproperty
    property p_pair_exact;
        $rose(pair_n) |-> pair_lo_q == 16'(PAIR_CYC);
    endproperty
    property p_pair_gap;
        $fell(pair_n) |-> pair_hi_q >= 16'(PAIR_CYC);
    endproperty
    property p_quiet;
        armed_q && link_detect_out_n && (!pair_n || pair_hi_q > 16'h3)
            |-> !rsp_valid;
    endproperty
    property p_no_pair_in_rst;
        !rst_n |-> pair_n;
    endproperty

    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response strobe longer than one cycle");
    a_conn_linked: assert property (p_conn_linked)
        else $error("connect response without link detect low");
    a_disc_unlinked: assert property (p_disc_unlinked)
        else $error("disconnect response with link detect low");
    a_rst_min: assert property (p_rst_min)
        else $error("reset pin low too briefly");
    a_rst_exact: assert property (p_rst_exact)
        else $error("reset pin hold differs from required length");
    a_pair_min: assert property (p_pair_min)
        else $error("pairing pin low too briefly");
    a_pair_exact: assert property (p_pair_exact)
        else $error("pairing pin low hold differs from required length");
    a_pair_gap: assert property (p_pair_gap)
        else $error("pairing pin high gap too short");
    a_quiet: assert property (p_quiet)
        else $error("response sent while pairing by pin");
    a_no_pair_in_rst: assert property (p_no_pair_in_rst)
        else $error("pairing pin low during factory reset");
endmodule
`default_nettype wire

// ---- verif/tb_pairing_status_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_pairing_status_pins;
    import psp_pkg::*;
    localparam int unsigned RC = 20;
    localparam int unsigned PC = 40;
    logic        clk, rst, wr, rd, irq, link_up, cmd_done, cmd_ok;
    logic        set_valid, set_auth, set_encr, set_rsp_en;
    logic        def_a, def_b, master_a, auth_a, encr_a, rsp_en_a, pairing_a;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [15:0] set_pin, pin_a;
    psp_mode_t   set_mode, mode_a, mode_b;
    int          err_count, tests_run, def_a_n, def_b_n, n;

    psp_if ifa ();
    psp_if ifb ();
    psp_host #(.RST_CYC(RC), .PAIR_CYC(PC)) i_psp_host (.i_clk(clk),
        .i_rst(rst), .pins(ifa), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
    psp_device #(.RST_CYC(RC), .PAIR_CYC(PC)) i_psp_device (.i_clk(clk),
        .i_rst(rst), .pins(ifa), .i_link_up(link_up), .i_cmd_done(cmd_done),
        .i_cmd_ok(cmd_ok), .i_set_valid(set_valid), .i_set_mode(set_mode),
        .i_set_auth(set_auth), .i_set_encr(set_encr),
        .i_set_rsp_en(set_rsp_en), .i_set_pin(set_pin), .o_defaults(def_a),
        .o_mode(mode_a), .o_master(master_a), .o_auth_en(auth_a),
        .o_encr_en(encr_a), .o_pin_code(pin_a), .o_rsp_en(rsp_en_a),
        .o_pairing(pairing_a));
    // A second unit whose pins the bench drives with short holds and one full reset hold.
    psp_device #(.RST_CYC(RC), .PAIR_CYC(PC)) i_psp_device_flt (.i_clk(clk),
        .i_rst(rst), .pins(ifb), .i_link_up(link_up), .i_cmd_done(cmd_done),
        .i_cmd_ok(cmd_ok), .i_set_valid(set_valid), .i_set_mode(set_mode),
        .i_set_auth(set_auth), .i_set_encr(set_encr),
        .i_set_rsp_en(set_rsp_en), .i_set_pin(set_pin), .o_defaults(def_b),
        .o_mode(mode_b), .o_master(), .o_auth_en(), .o_encr_en(),
        .o_pin_code(), .o_rsp_en(), .o_pairing());
    psp_checker #(.RST_CYC(RC), .PAIR_CYC(PC)) i_psp_checker (.i_clk(clk),
        .i_rst(rst), .rst_n(ifa.rst_n), .pair_n(ifa.pair_n),
        .link_detect_out_n(ifa.link_detect_out_n),
        .rsp_valid(ifa.rsp_valid), .rsp_kind(ifa.rsp_kind));

    // ========================================================
    // Clock, pulse counters and shared tasks.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        def_a_n += (def_a === 1'b1);
        def_b_n += (def_b === 1'b1);
    end
    task automatic check_val(input string name, input logic [31:0] seen,
                             input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic ev(input int k);
        @(posedge clk);
        cmd_done <= (k < 2);
        cmd_ok <= (k == 0);
        if (k >= 2) link_up <= (k == 2);
        @(posedge clk);
        cmd_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic setv(input psp_mode_t m, input logic au, input logic en,
                        input logic rs, input logic [15:0] p);
        @(posedge clk);
        set_valid <= 1'b1;
        set_mode <= m;
        set_auth <= au;
        set_encr <= en;
        set_rsp_en <= rs;
        set_pin <= p;
        @(posedge clk);
        set_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_idle();
        logic [31:0] s = 32'h1;
        for (int i = 0; i < 300 && s[ST_BUSY] !== 1'b0; i++) begin
            rd_reg(REG_STATUS, s);
        end
        repeat (4) @(posedge clk);
        check_val("busy", s[ST_BUSY], 32'h0);
    endtask
    // Measures how many cycles a host pin stays low (1: pairing pin).
    task automatic lo_len(input bit sel, output int cnt);
        cnt = 0;
        #1;
        while ((sel ? ifa.pair_n : ifa.rst_n) === 1'b0 && cnt < 1000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask
    task automatic pulse_b(input bit sel, input int len);
        @(posedge clk);
        if (sel) ifb.pair_n <= 1'b0;
        else ifb.rst_n <= 1'b0;
        repeat (len) @(posedge clk);
        ifb.pair_n <= 1'b1;
        ifb.rst_n <= 1'b1;
        repeat (3 * PC) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("tests run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ========================================================
    // Watchdog: the sequence needs under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    // ========================================================
    // Main sequence.
    initial begin
        {err_count, tests_run, def_a_n, def_b_n} = '0;
        {rst, wr, rd, link_up, cmd_done, cmd_ok} = 6'h20;
        {set_valid, set_auth, set_encr, set_rsp_en} = 4'h0;
        {addr, wdata, set_pin} = '0;
        set_mode = command_wait_mode;
        ifb.rst_n = 1'b1;
        ifb.pair_n = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(REG_STATUS, d);
        check_val("status", d, 32'h0);
        rd_reg(REG_IRQ_MASK, d);
        check_val("irq mask", d, {28'h0, RST_IRQ_MASK});
        rd_reg(4'h9, d);
        check_val("unmapped", d, 32'h0);
        check_val("mode", mode_a, command_wait_mode);
        check_val("detect idle", ifa.link_detect_out_n, 32'h1);
        $display("test reset values done");
        wr_reg(REG_IRQ_MASK, 32'hf);
        for (int k = 0; k < 4; k++) begin
            ev(k);
            rd_reg(REG_STATUS, d);
            check_val("kind", d[3:2], k);
            check_val("detect", ifa.link_detect_out_n, k != 2);
        end
        rd_reg(REG_IRQ_STAT, d);
        check_val("irq stat", d, 32'h7);
        check_val("irq", irq, 32'h1);
        wr_reg(REG_IRQ_STAT, 32'hf);
        wr_reg(REG_IRQ_MASK, 32'h0);
        ev(0);
        check_val("irq masked", irq, 32'h0);
        rd_reg(REG_IRQ_STAT, d);
        check_val("irq stat masked", d, 32'h4);
        wr_reg(REG_IRQ_STAT, 32'hf);
        setv(command_wait_mode, 1'b0, 1'b0, 1'b0, 16'h0);
        ev(1);
        rd_reg(REG_IRQ_STAT, d);
        check_val("rsp off", d, 32'h0);
        for (int m = 0; m < 4; m++) begin
            setv(psp_mode_t'(m), 1'b1, 1'b1, 1'b1, 16'h5a3c);
            check_val("set mode", mode_a, m);
        end
        check_val("security", {auth_a, encr_a, pin_a}, 32'h35a3c);
        $display("test responses done");
        wr_reg(REG_CTRL, 32'h1);
        lo_len(1'b0, n);
        check_val("reset hold", n, RC);
        wait_idle();
        check_val("defaults", def_a_n, 32'h1);
        check_val("restored", {mode_a, auth_a, encr_a, pin_a, rsp_en_a},
                  {2'h0, RST_AUTH, RST_ENCR, RST_PIN, RST_RSP_EN});
        rd_reg(REG_IRQ_STAT, d);
        check_val("done", d, 32'h8);
        wr_reg(REG_IRQ_STAT, 32'hf);
        $display("test factory reset done");
        wr_reg(REG_CTRL, 32'h2);
        lo_len(1'b1, n);
        check_val("pair hold", n, PC);
        wait_idle();
        check_val("first mode", mode_a, open_accept_mode);
        check_val("quiet", {pairing_a, rsp_en_a}, 32'h2);
        ev(0);
        rd_reg(REG_IRQ_STAT, d);
        check_val("no rsp", d, 32'h8);
        ev(2);
        check_val("slave", {master_a, mode_a}, reconnect_accept_mode);
        ev(3);
        $display("test first unit done");
        wr_reg(REG_CTRL, 32'h1);
        wait_idle();
        wr_reg(REG_CTRL, 32'h4);
        lo_len(1'b1, n);
        check_val("pair hold 2", n, PC);
        repeat (5) @(posedge clk);
        check_val("mid mode", mode_a, open_accept_mode);
        wait_idle();
        check_val("second mode", mode_a, reconnect_initiate_mode);
        ev(2);
        check_val("master", master_a, 32'h1);
        ev(3);
        $display("test second unit done");
        setv(reconnect_accept_mode, 1'b0, 1'b0, 1'b1, 16'h0);
        pulse_b(1'b0, RC - 5);
        check_val("short reset", {def_b_n[1:0], mode_b}, 32'h2);
        pulse_b(1'b1, PC - 5);
        check_val("short pair", mode_b, reconnect_accept_mode);
        pulse_b(1'b0, RC);
        check_val("full reset", {def_b_n[1:0], mode_b}, 32'h4);
        $display("test short holds done");
        end_of_test();
    end
endmodule
`default_nettype wire
